// >>> hw/ilgs_addr_calc.sv
// indexed element address: base plus shifted (item count + group offset)
`timescale 1ns/100ps
module ilgs_addr_calc
  import ilgs_pkg::*;
(
  input  wire logic [ILGS_AW-1:0] i_base,   // base bit address
  input  wire logic [ILGS_AW-1:0] i_count,  // item count
  input  wire logic [ILGS_GW-1:0] i_offs,   // element offset in group
  input  wire logic [2:0]         i_shift,  // count to bit-address shift
  output logic      [ILGS_AW-1:0] o_addr    // computed bit address
);

  logic [ILGS_AW-1:0] items;

  // group members follow the indexed element at consecutive addresses
  always_comb begin
    items  = i_count + {{(ILGS_AW-ILGS_GW){1'b0}}, i_offs};
    o_addr = i_base + (items << i_shift);
  end

endmodule : ilgs_addr_calc

// >>> hw/ilgs_engine.sv
// indexed list gather and scatter transfer engine
// How it works
// - index is the low 48 bits of each 64-bit index element
// - gather fetches element at base plus count, packs it into result
// - count shifts left five for 32-bit, six for 64-bit elements
// - gather repeats per index element until the index list ends
// - index elements are 64-bit; subfunction bit 0 picks element size
// - gather bit 6 moves equal groups, length from source descriptor top
// - gather bit 7 reads source elements from the register file
// - gather leaves every data flag bit unchanged
// - scatter stores next source element at result base plus count
// - scatter continues until the index list length is consumed
// - scatter bit 4 without bit 6 broadcasts one source element
// - scatter bit 6 stores equal groups, length from result descriptor
// - scatter bit 7 stores result elements into the register file
// - register file as memory only for gather and scatter
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module ilgs_engine
  import ilgs_pkg::*;
#(
  parameter int LW = 32                          // index count width
)(
  input  wire logic               i_sys_clk,     // system clock
  input  wire logic               i_rst_n,       // async reset, low
  input  wire logic [7:0]         i_addr,        // register byte address
  input  wire logic [ILGS_DW-1:0] i_wdata,       // register write data
  input  wire logic               i_wr,          // register write strobe
  input  wire logic               i_rd,          // register read strobe
  output logic      [ILGS_DW-1:0] o_rdata,       // read data, next cycle
  output logic                    o_mem_req,     // stream request
  output logic                    o_mem_we,      // request is a store
  output logic                    o_mem_rf,      // target is register file
  output logic                    o_mem_w64,     // 64-bit element access
  output logic      [ILGS_AW-1:0] o_mem_addr,    // bit address
  output logic      [ILGS_DW-1:0] o_mem_wdata,   // store data
  input  wire logic               i_mem_ack,     // request completed
  input  wire logic [ILGS_DW-1:0] i_mem_rdata,   // load data with ack
  output logic                    o_busy         // instruction running
);

  // software visible state
  ilgs_op_t           op_ff;
  logic [7:0]         g_ff;
  logic [ILGS_AW-1:0] idx_base_ff;
  logic [LW-1:0]      idx_len_ff;
  logic [ILGS_DW-1:0] src_desc_ff;
  logic [ILGS_DW-1:0] dst_desc_ff;
  logic               done_ff;
  logic               err_ff;
  logic [LW-1:0]      moved_ff;
  logic [ILGS_DW-1:0] rdata_ff;

  // sequencer state
  ilgs_state_t        state_ff;
  ilgs_state_t        nxt_state;
  logic [LW-1:0]      idx_i_ff;
  logic [IDX_CNT_W-1:0] idx_cnt_ff;
  logic [ILGS_GW-1:0] grp_k_ff;
  logic [LW-1:0]      seq_ff;
  logic [ILGS_DW-1:0] elem_ff;
  logic               have_ff;
  logic               req_ff;
  logic               we_ff;
  logic               rf_ff;
  logic [ILGS_AW-1:0] maddr_ff;

  // decoded controls
  logic               is_gather;
  logic               is_scatter;
  logic               w64;
  logic [2:0]         esh;
  logic               grp_mode;
  logic               bcast;
  logic [ILGS_GW-1:0] grp_len;
  logic               ctrl_wr;
  logic               start;
  ilgs_op_t           wr_op;
  logic               ack;
  logic               last_elem;
  logic               last_idx;
  logic [ILGS_AW-1:0] ind_base;
  logic [ILGS_AW-1:0] ind_addr;
  logic [ILGS_AW-1:0] seq_base;
  logic [ILGS_AW-1:0] seq_addr;
  logic [ILGS_AW-1:0] idx_addr;

  // operation and subfunction decode
  always_comb begin
    is_gather  = (op_ff == OP_GATHER);
    is_scatter = (op_ff == OP_SCATTER);
    w64        = g_ff[G_SIZE64];
    esh        = ilgs_shift(w64);
    grp_mode   = g_ff[G_GROUP];
    bcast      = is_scatter && g_ff[G_BCAST] && !g_ff[G_GROUP];
  end

  // group length from the descriptor of the indexed vector
  always_comb begin
    if (!grp_mode) begin
      grp_len = {{(ILGS_GW-1){1'b0}}, 1'b1};
    end else if (is_gather) begin
      grp_len = src_desc_ff[ILGS_DW-1:DESC_LEN_LO];
    end else begin
      grp_len = dst_desc_ff[ILGS_DW-1:DESC_LEN_LO];
    end
  end

  // start decode from a control write
  always_comb begin
    ctrl_wr = i_wr && (i_addr == REG_CTRL);
    wr_op   = ilgs_op_t'(i_wdata[CTRL_OP_LO +: 2]);
    start   = ctrl_wr && i_wdata[CTRL_START] && (state_ff == ST_IDLE);
    ack     = req_ff && i_mem_ack;
  end

  // sequence end tests
  always_comb begin
    last_elem = (grp_k_ff == grp_len - {{(ILGS_GW-1){1'b0}}, 1'b1});
    last_idx  = (idx_i_ff == idx_len_ff - {{(LW-1){1'b0}}, 1'b1});
  end

  // indexed side uses source base for gather, result base for scatter
  always_comb begin
    ind_base = is_gather ? src_desc_ff[ILGS_AW-1:0]
                         : dst_desc_ff[ILGS_AW-1:0];
    seq_base = is_gather ? dst_desc_ff[ILGS_AW-1:0]
                         : src_desc_ff[ILGS_AW-1:0];
    seq_addr = seq_base + ({{(ILGS_AW-LW){1'b0}}, seq_ff} << esh);
    idx_addr = idx_base_ff
             + ({{(ILGS_AW-LW){1'b0}}, idx_i_ff} << SH_FULL);
  end

  // base plus shifted sum of item count and group offset
  ilgs_addr_calc u_addr (
    .i_base  (ind_base),
    .i_count (idx_cnt_ff),
    .i_offs  (grp_k_ff),
    .i_shift (esh),
    .o_addr  (ind_addr)
  );

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start &&
            (wr_op == OP_GATHER || wr_op == OP_SCATTER)) begin
          nxt_state = ST_FIDX;
        end
      end
      ST_FIDX: begin
        if (idx_len_ff == '0) begin
          nxt_state = ST_IDLE;
        end else if (ack) begin
          if (grp_len == '0) begin
            nxt_state = ST_NEXT;
          end else if (bcast && have_ff) begin
            nxt_state = ST_WR;
          end else begin
            nxt_state = ST_RD;
          end
        end
      end
      ST_RD: begin
        if (ack) begin
          nxt_state = ST_WR;
        end
      end
      ST_WR: begin
        if (ack) begin
          if (last_elem) begin
            nxt_state = ST_NEXT;
          end else if (bcast) begin
            nxt_state = ST_WR;
          end else begin
            nxt_state = ST_RD;
          end
        end
      end
      ST_NEXT: begin
        nxt_state = last_idx ? ST_IDLE : ST_FIDX;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // stream request: issued whenever none is pending in ST_RD or ST_WR, or in ST_FIDX with a non-empty index list, dropped on ack
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_ff   <= 1'b0;
      we_ff    <= 1'b0;
      rf_ff    <= 1'b0;
      maddr_ff <= '0;
    end else if (ack) begin
      req_ff <= 1'b0;
      we_ff  <= 1'b0;
      rf_ff  <= 1'b0;
    end else if (!req_ff) begin
      case (state_ff)
        ST_FIDX: begin
          req_ff   <= (idx_len_ff != '0);
          we_ff    <= 1'b0;
          rf_ff    <= 1'b0;
          maddr_ff <= idx_addr;
        end
        ST_RD: begin
          req_ff   <= 1'b1;
          we_ff    <= 1'b0;
          rf_ff    <= is_gather && g_ff[G_REGF];
          maddr_ff <= is_gather ? ind_addr : seq_addr;
        end
        ST_WR: begin
          req_ff   <= 1'b1;
          we_ff    <= 1'b1;
          rf_ff    <= is_scatter && g_ff[G_REGF];
          maddr_ff <= is_scatter ? ind_addr : seq_addr;
        end
        default: begin
          req_ff <= 1'b0;
          we_ff  <= 1'b0;
          rf_ff  <= 1'b0;
        end
      endcase
    end
  end

  // index pointer and latched item count
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_i_ff   <= '0;
      idx_cnt_ff <= '0;
    end else if (start) begin
      idx_i_ff <= '0;
    end else if (state_ff == ST_FIDX && ack) begin
      idx_cnt_ff <= i_mem_rdata[IDX_CNT_W-1:0];
    end else if (state_ff == ST_NEXT) begin
      idx_i_ff <= idx_i_ff + {{(LW-1){1'b0}}, 1'b1};
    end
  end

  // group member counter, restarted per index element
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grp_k_ff <= '0;
    end else if (state_ff == ST_FIDX) begin
      grp_k_ff <= '0;
    end else if (state_ff == ST_WR && ack) begin
      grp_k_ff <= grp_k_ff + {{(ILGS_GW-1){1'b0}}, 1'b1};
    end
  end

  // sequential element pointer on the packed vector
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_ff <= '0;
    end else if (start) begin
      seq_ff <= '0;
    end else if (state_ff == ST_WR && ack && !bcast) begin
      seq_ff <= seq_ff + {{(LW-1){1'b0}}, 1'b1};
    end
  end

  // element holding register; broadcast keeps its first fetch
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      elem_ff <= RST_WORD;
      have_ff <= 1'b0;
    end else if (start) begin
      have_ff <= 1'b0;
    end else if (state_ff == ST_RD && ack) begin
      elem_ff <= w64 ? i_mem_rdata
                     : {{(ILGS_DW/2){1'b0}}, i_mem_rdata[ILGS_DW/2-1:0]};
      have_ff <= 1'b1;
    end
  end

  // transfer count and completion; no data flags are ever produced
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      moved_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      if (start) begin
        moved_ff <= '0;
      end else if (state_ff == ST_WR && ack) begin
        moved_ff <= moved_ff + {{(LW-1){1'b0}}, 1'b1};
      end
      if (state_ff != ST_IDLE && nxt_state == ST_IDLE) begin
        done_ff <= 1'b1;
      end else if (i_wr && i_addr == REG_STAT && i_wdata[STAT_DONE]) begin
        done_ff <= 1'b0;
      end
    end
  end

  // software registers; reserved op codes refuse to start
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_ff       <= OP_NONE;
      g_ff        <= RST_G;
      idx_base_ff <= '0;
      idx_len_ff  <= '0;
      src_desc_ff <= RST_WORD;
      dst_desc_ff <= RST_WORD;
      err_ff      <= 1'b0;
    end else if (i_wr && state_ff == ST_IDLE) begin
      case (i_addr)
        REG_CTRL: begin
          op_ff  <= wr_op;
          g_ff   <= i_wdata[CTRL_G_LO +: 8];
          err_ff <= i_wdata[CTRL_START] &&
                    !(wr_op == OP_GATHER || wr_op == OP_SCATTER);
        end
        REG_IDX_BASE: idx_base_ff <= i_wdata[ILGS_AW-1:0];
        REG_IDX_LEN:  idx_len_ff  <= i_wdata[LW-1:0];
        REG_SRC_DESC: src_desc_ff <= i_wdata;
        REG_DST_DESC: dst_desc_ff <= i_wdata;
        default: begin
          err_ff <= err_ff;
        end
      endcase
    end
  end

  // read data returned one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= RST_WORD;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL: begin
          rdata_ff <= '0;
          rdata_ff[CTRL_OP_LO +: 2] <= op_ff;
          rdata_ff[CTRL_G_LO +: 8]  <= g_ff;
        end
        REG_STAT: begin
          rdata_ff <= '0;
          rdata_ff[STAT_BUSY] <= (state_ff != ST_IDLE);
          rdata_ff[STAT_DONE] <= done_ff;
          rdata_ff[STAT_ERR]  <= err_ff;
          rdata_ff[STAT_CNT_LO +: LW] <= moved_ff;
        end
        REG_IDX_BASE: rdata_ff <= {{(ILGS_DW-ILGS_AW){1'b0}}, idx_base_ff};
        REG_IDX_LEN:  rdata_ff <= {{(ILGS_DW-LW){1'b0}}, idx_len_ff};
        REG_SRC_DESC: rdata_ff <= src_desc_ff;
        REG_DST_DESC: rdata_ff <= dst_desc_ff;
        default:      rdata_ff <= RST_WORD;
      endcase
    end
  end

  // busy flag register for the output
  logic busy_ff;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  // outputs straight from flip-flops
  assign o_rdata     = rdata_ff;
  assign o_mem_req   = req_ff;
  assign o_mem_we    = we_ff;
  assign o_mem_rf    = rf_ff;
  assign o_mem_w64   = w64;
  assign o_mem_addr  = maddr_ff;
  assign o_mem_wdata = elem_ff;
  assign o_busy      = busy_ff;

endmodule : ilgs_engine

// >>> hw/ilgs_pkg.sv
// constants and types shared by the indexed list gather/scatter engine
package ilgs_pkg;

  // address and data widths of the stream side
  localparam int ILGS_AW = 48;
  localparam int ILGS_DW = 64;
  localparam int ILGS_GW = 16;

  // register byte offsets on the software port
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STAT     = 8'h08;
  localparam logic [7:0] REG_IDX_BASE = 8'h10;
  localparam logic [7:0] REG_IDX_LEN  = 8'h18;
  localparam logic [7:0] REG_SRC_DESC = 8'h20;
  localparam logic [7:0] REG_DST_DESC = 8'h28;

  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_G_LO  = 8;

  // status register fields
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_ERR    = 2;
  localparam int STAT_CNT_LO = 16;

  // subfunction bit positions
  localparam int G_SIZE64 = 0;
  localparam int G_BCAST  = 4;
  localparam int G_GROUP  = 6;
  localparam int G_REGF   = 7;

  // descriptor layout: group length on top, base below
  localparam int DESC_LEN_LO = 48;

  // index item count occupies the low bits of an index element
  localparam int IDX_CNT_W = 48;

  // left shifts turning item counts into bit addresses
  localparam logic [2:0] SH_HALF = 3'h5;
  localparam logic [2:0] SH_FULL = 3'h6;

  // reset values
  localparam logic [63:0] RST_WORD = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  RST_G    = 8'h00;

  // operation select
  typedef enum logic [1:0] {
    OP_NONE    = 2'b00,
    OP_GATHER  = 2'b01,
    OP_SCATTER = 2'b10,
    OP_RSVD    = 2'b11
  } ilgs_op_t;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FIDX = 5'b00010,
    ST_RD   = 5'b00100,
    ST_WR   = 5'b01000,
    ST_NEXT = 5'b10000
  } ilgs_state_t;

  // element size select to address shift
  function automatic logic [2:0] ilgs_shift(input logic is64);
    ilgs_shift = is64 ? SH_FULL : SH_HALF;
  endfunction : ilgs_shift

endpackage : ilgs_pkg

// >>> verif/ilgs_engine_properties.sv
// port-level assertion checker for the gather/scatter engine
`timescale 1ns/100ps
module ilgs_engine_chk
  import ilgs_pkg::*;
#(
  parameter int LW = 32                     // index count width
)(
  input wire logic               i_sys_clk,   // clock
  input wire logic               i_rst_n,     // reset, low
  input wire logic [7:0]         i_addr,      // reg address
  input wire logic [ILGS_DW-1:0] i_wdata,     // reg wdata
  input wire logic               i_wr,        // write strobe
  input wire logic               i_rd,        // read strobe
  input wire logic [ILGS_DW-1:0] o_rdata,     // read data
  input wire logic               o_mem_req,   // stream req
  input wire logic               o_mem_we,    // store
  input wire logic               o_mem_rf,    // register file
  input wire logic               o_mem_w64,   // 64-bit elem
  input wire logic [ILGS_AW-1:0] o_mem_addr,  // bit address
  input wire logic [ILGS_DW-1:0] o_mem_wdata, // store data
  input wire logic               i_mem_ack,   // ack
  input wire logic               o_busy       // running
);
  logic       go;
  logic [1:0] op_ff;
  logic [7:0] g_ff;
  logic       len_ff;

  // an accepted start with a legal operation and a non-empty list
  assign go = i_wr && i_addr == REG_CTRL && i_wdata[CTRL_START] && !o_busy
              && ^i_wdata[2:1] && len_ff;

  // remember the operation and subfunction the engine is running
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_ff  <= 2'h0;
      g_ff   <= 8'h00;
      len_ff <= 1'b0;
    end else if (i_wr && !o_busy) begin
      if (i_addr == REG_CTRL) begin
        op_ff <= i_wdata[2:1];
        g_ff  <= i_wdata[15:8];
      end
      if (i_addr == REG_IDX_LEN) len_ff <= |i_wdata[31:0];
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req &&
    $stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_wdata))
    else $error("stream request changed before ack");
  chk_req_gap: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("request not dropped after ack");
  chk_busy_req: assert property (o_mem_req |-> o_busy)
    else $error("request while idle");
  chk_rf_dir: assert property (o_mem_req && o_mem_rf |-> g_ff[G_REGF] &&
    o_mem_we == (op_ff == OP_SCATTER))
    else $error("register file access of wrong kind");
  chk_store_size: assert property (o_mem_req && o_mem_we |->
    o_mem_w64 == g_ff[G_SIZE64])
    else $error("store size differs from subfunction");
  chk_store_rf: assert property (o_mem_req && o_mem_we &&
    op_ff == OP_SCATTER |-> o_mem_rf == g_ff[G_REGF])
    else $error("scatter store target wrong");
  chk_half_ext: assert property (o_mem_req && o_mem_we && !o_mem_w64 |->
    o_mem_wdata[63:32] == 32'h0)
    else $error("half word store not zero extended");
  chk_start_busy: assert property (go |=> o_busy)
    else $error("busy not raised after start");
  chk_start_req: assert property (go |-> ##[2:3] o_mem_req)
    else $error("no index fetch after start");
  chk_unmapped: assert property (i_rd && i_addr == 8'h30 |=> o_rdata == 64'h0)
    else $error("unmapped read not zero");

  cov_group: cover property (o_mem_req && o_mem_we && g_ff[G_GROUP]);
  cov_bcast: cover property (o_mem_req && o_mem_we && g_ff[G_BCAST]);
  cov_rf: cover property (o_mem_req && o_mem_rf && i_mem_ack);
endmodule : ilgs_engine_chk

bind ilgs_engine ilgs_engine_chk #(.LW(LW)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_rf(o_mem_rf),
  .o_mem_w64(o_mem_w64), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .o_busy(o_busy));

// >>> verif/ilgs_engine_tb.sv
// self-checking bench for gather and scatter runs over the register port
`timescale 1ns/100ps
module ilgs_engine_tb
  import ilgs_pkg::*;
;
  logic               i_sys_clk = 1'b0;
  logic               i_rst_n   = 1'b0;
  logic [7:0]         i_addr    = 8'h00;
  logic [ILGS_DW-1:0] i_wdata   = '0;
  logic               i_wr      = 1'b0;
  logic               i_rd      = 1'b0;
  logic [3:0]         lat       = 4'h0;
  logic [ILGS_DW-1:0] o_rdata, o_mem_wdata, i_mem_rdata;
  logic [ILGS_AW-1:0] o_mem_addr;
  logic               o_mem_req, o_mem_we, o_mem_rf, o_mem_w64;
  logic               i_mem_ack, o_busy;
  int                 err_count = 0;
  int                 cmp_count = 0;

  // 200 MHz clock
  always #2.5 i_sys_clk = ~i_sys_clk;

  ilgs_engine dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_rf(o_mem_rf), .o_mem_w64(o_mem_w64), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .o_busy(o_busy));

  ilgs_mem_model u_mem (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_req(o_mem_req), .i_we(o_mem_we), .i_rf(o_mem_rf),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_lat(lat),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

  // compare and count
  task automatic check(input string nm, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // verdict and stop
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [63:0] d);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // expected contents of an unwritten model location
  function automatic logic [63:0] pat(input logic [48:0] k);
    pat = {15'h0, k} ^ 64'hc3c3_0000_0000_0000;
  endfunction : pat

  // program, start, await done, then check every element and count
  task automatic run(input ilgs_op_t op, input logic [7:0] g, input int n,
                     input logic [15:0] gl);
    logic [63:0] s, e;
    logic [47:0] sb, db, sa, da;
    logic [2:0]  sh;
    int          m, ld0, st0;
    bit          sc, bc;
    sc  = (op == OP_SCATTER);
    bc  = sc && g[4] && !g[6];
    sh  = g[0] ? 3'h6 : 3'h5;
    m   = g[6] ? int'(gl) : 1;
    sb  = (g[7] && !sc) ? 48'h100 : 48'h2_0000;
    db  = (g[7] && sc) ? 48'h200 : 48'h4_0000;
    ld0 = u_mem.n_ld;
    st0 = u_mem.n_st;
    u_mem.mem.delete();
    for (int i = 0; i < n; i++)
      u_mem.mem[{1'b0, 48'h1000 + 48'(i * 64)}] = {16'hbeef, 48'(i * 3 + 1)};
    wr(REG_STAT, 64'h2);
    wr(REG_IDX_BASE, 64'h1000);
    wr(REG_IDX_LEN, 64'(n));
    wr(REG_SRC_DESC, {sc ? 16'h9 : gl, sb});
    wr(REG_DST_DESC, {sc ? gl : 16'h9, db});
    wr(REG_CTRL, {48'h0, g, 5'h0, op, 1'b1});
    for (int t = 0; t <= 100; t++) begin
      rd(REG_STAT, s);
      if (s[STAT_DONE] === 1'b1) break;
      if (t == 100) begin
        check("done", 64'h0, 64'h1);
        end_of_test;
      end
    end
    for (int j = 0; j < n * m; j++) begin
      sa = 48'(j / m * 3 + 1 + j % m) << sh;
      da = 48'(j) << sh;
      e  = sc ? pat({1'b0, bc ? sb : sb + da}) : pat({g[7], sb + sa});
      da = sc ? db + sa : db + da;
      if (!g[0]) e[63:32] = 32'h0;
      check("element", u_mem.mem[{sc & g[7], da}], e);
    end
    check("stores", 64'(u_mem.n_st - st0), 64'(n * m));
    check("loads", 64'(u_mem.n_ld - ld0), 64'(n + (bc ? 1 : n * m)));
    rd(REG_STAT, s);
    check("status", s, {16'h0, 32'(n * m), 16'h2});
    $display("test %s g=%h finished", op.name(), g);
  endtask : run

  // main sequence
  initial begin
    logic [63:0] d;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(REG_STAT, d);
    check("status reset", d, 64'h0);
    rd(REG_DST_DESC, d);
    check("descriptor reset", d, 64'h0);
    wr(REG_SRC_DESC, 64'h0003_1234_5678_9abc);
    rd(REG_SRC_DESC, d);
    check("descriptor", d, 64'h0003_1234_5678_9abc);
    rd(8'h30, d);
    check("unmapped", d, 64'h0);
    $display("test registers finished");
    run(OP_GATHER, 8'h00, 3, 16'h5);
    lat <= 4'h3;
    run(OP_GATHER, 8'h41, 2, 16'h3);
    run(OP_GATHER, 8'h81, 3, 16'h5);
    run(OP_SCATTER, 8'h00, 3, 16'h5);
    lat <= 4'h0;
    run(OP_SCATTER, 8'h11, 3, 16'h5);
    run(OP_SCATTER, 8'h40, 2, 16'h2);
    run(OP_SCATTER, 8'h81, 3, 16'h5);
    run(OP_SCATTER, 8'h40, 2, 16'h0);
    wr(REG_CTRL, 64'h7);
    rd(REG_STAT, d);
    check("reserved op", 64'(d[STAT_ERR]), 64'h1);
    run(OP_GATHER, 8'h00, 0, 16'h5);
    wr(REG_CTRL, 64'h1);
    rd(REG_STAT, d);
    check("error flag", 64'(d[STAT_ERR]), 64'h1);
    $display("test bad operation finished");
    end_of_test;
  end
endmodule : ilgs_engine_tb

// >>> verif/ilgs_mem_model.sv
// central memory and register file model behind the stream port
`timescale 1ns/100ps
module ilgs_mem_model
  import ilgs_pkg::*;
(
  input  wire logic               i_sys_clk, // clock
  input  wire logic               i_rst_n,   // reset, low
  input  wire logic               i_req,     // request
  input  wire logic               i_we,      // store
  input  wire logic               i_rf,      // register file
  input  wire logic [ILGS_AW-1:0] i_addr,    // bit address
  input  wire logic [ILGS_DW-1:0] i_wdata,   // store data
  input  wire logic [3:0]         i_lat,     // ack delay
  output logic                    o_ack,     // done pulse
  output logic      [ILGS_DW-1:0] o_rdata    // load data
);
  logic [ILGS_DW-1:0] mem [logic [ILGS_AW:0]];
  logic [3:0]         cnt;
  int                 n_ld = 0;
  int                 n_st = 0;

  // answer each request after i_lat waiting cycles; idle data toggles
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack   <= 1'b0;
      cnt     <= 4'h0;
      o_rdata <= '0;
    end else if (o_ack || !i_req || cnt != i_lat) begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      cnt     <= (i_req && !o_ack) ? cnt + 4'h1 : 4'h0;
    end else begin
      cnt   <= 4'h0;
      o_ack <= 1'b1;
      if (i_we) begin
        mem[{i_rf, i_addr}] = i_wdata;
        n_st++;
      end else begin
        o_rdata <= mem.exists({i_rf, i_addr}) ? mem[{i_rf, i_addr}]
                   : {15'h0, i_rf, i_addr} ^ 64'hc3c3_0000_0000_0000;
        n_ld++;
      end
    end
  end
endmodule : ilgs_mem_model
